/* File: sim/iapw_core_model.sv */
// core-side model issuing interrupt-acknowledge cycles
`timescale 1ns/1ps
module iapw_core_model (
   input  wire logic       pclk,
   input  wire logic       interrupt_acknowledge_valid,
   input  wire logic [7:0] interrupt_acknowledge_vector,
   output logic            interrupt_acknowledge_req,
   output logic [2:0]      interrupt_acknowledge_level
);
   initial begin
      interrupt_acknowledge_req   = 1'b0;
      interrupt_acknowledge_level = 3'h1;
   end
   // level is held until the answer; afterwards it is scrambled so no stale value helps
   task automatic ack(input logic [2:0] lvl, output logic [7:0] vec, output logic ok);
      int i;
      @(posedge pclk);
      interrupt_acknowledge_req   <= 1'b1;
      interrupt_acknowledge_level <= lvl;
      @(posedge pclk);
      interrupt_acknowledge_req <= 1'b0;
      ok = 1'b0;
      vec = 8'h00;
      for (i = 0; i < 8 && !ok; i++) begin
         @(posedge pclk);
         if (interrupt_acknowledge_valid === 1'b1) begin
            ok = 1'b1;
            vec = interrupt_acknowledge_vector;
         end
      end
      interrupt_acknowledge_level <= ~lvl;
   endtask
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the acknowledge, priority and wake block
`timescale 1ns/1ps
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        interrupt_acknowledge_req, interrupt_acknowledge_valid, cpu_stopped, wake_up, err, ok;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  interrupt_acknowledge_level;
   logic [7:0]  interrupt_acknowledge_vector, vec;
   logic [63:0] pend, msk, frc;
   int          mismatches, checked, i;
   typedef struct {int a; int b; int m; int f; logic [11:0] ad; logic [7:0] v; logic [7:0] c;} iapw_row_t;
   iapw_row_t   rows [11];

   iapw_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_pending(pend[63:1]), .source_mask_bits(msk[63:1]),
      .software_force_bits(frc[63:1]), .interrupt_acknowledge_req(interrupt_acknowledge_req), .interrupt_acknowledge_level(interrupt_acknowledge_level),
      .interrupt_acknowledge_vector(interrupt_acknowledge_vector), .interrupt_acknowledge_valid(interrupt_acknowledge_valid), .cpu_stopped(cpu_stopped),
      .wake_up(wake_up));
   iapw_core_model core (.pclk(pclk), .interrupt_acknowledge_valid(interrupt_acknowledge_valid), .interrupt_acknowledge_vector(interrupt_acknowledge_vector),
      .interrupt_acknowledge_req(interrupt_acknowledge_req), .interrupt_acknowledge_level(interrupt_acknowledge_level));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   // request held until pready is seen at an edge; data and error taken at that edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         mismatches++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~d;
   endtask

   task automatic set_src(input int a, input int b, input int m, input int f);
      logic [63:0] p;
      p = (64'h1 << a) | (64'h1 << b);
      @(posedge pclk);
      pend <= p;
      msk  <= ~p | (64'h1 << m);
      frc  <= 64'h1 << f;
   endtask

   task automatic do_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic reg_check;
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk("capture", 32'h0000_0000, rd);
      apb(1'b0, 12'h150, 32'h0000_0000);
      chk("ctrl20", 32'h0000_0000, rd);
      apb(1'b0, 12'h10C, 32'h0000_0000);
      chk("ctrl3", 32'h0000_0018, rd);
   endtask

   initial begin
      {psel, penable, pwrite, cpu_stopped} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pend = 64'h0;
      msk = 64'hFFFF_FFFF_FFFF_FFFF;
      frc = 64'h0;
      mismatches = 0;
      checked = 0;
      presetn = 1'b0;
      // line, line, masked, forced, address, vector, capture
      rows[0] = '{0, 0, 0, 0, 12'h000, 8'h00, 8'h00};
      rows[1] = '{20, 30, 0, 0, 12'h000, 8'h54, 8'h56};
      rows[2] = '{20, 30, 0, 0, 12'h014, 8'h54, 8'h56};
      rows[3] = '{20, 30, 20, 0, 12'h000, 8'h5E, 8'h52};
      rows[4] = '{0, 0, 0, 40, 12'h000, 8'h68, 8'h27};
      rows[5] = '{0, 0, 0, 40, 12'h028, 8'h68, 8'h27};
      rows[6] = '{3, 0, 0, 0, 12'h000, 8'h43, 8'h38};
      rows[7] = '{7, 20, 0, 0, 12'h000, 8'h47, 8'h78};
      rows[8] = '{10, 0, 0, 0, 12'h000, 8'h00, 8'h00};
      rows[9] = '{3, 50, 0, 0, 12'h000, 8'h72, 8'h34};
      rows[10] = '{3, 51, 0, 0, 12'h000, 8'h43, 8'h38};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      reg_check();
      // unique level/priority pairs only
      apb(1'b1, 12'h150, 32'h0000_002E);
      apb(1'b1, 12'h178, 32'h0000_002A);
      apb(1'b1, 12'h1A0, 32'h0000_0017);
      apb(1'b1, 12'h1C8, 32'h0000_001C);
      apb(1'b1, 12'h1CC, 32'h0000_001B);
      apb(1'b0, 12'h150, 32'h0000_0000);
      chk("ctrl20", 32'h0000_002E, rd);
      for (i = 0; i < 11; i++) begin
         set_src(rows[i].a, rows[i].b, rows[i].m, rows[i].f);
         apb(1'b0, rows[i].ad, 32'h0000_0000);
         chk("vector", {24'h0, rows[i].v}, rd);
         apb(1'b0, 12'h040, 32'h0000_0000);
         chk("capture", {24'h0, rows[i].c}, rd);
      end
      $display("test rows done");
      apb(1'b1, 12'h10C, 32'h0000_003F);
      apb(1'b0, 12'h10C, 32'h0000_0000);
      chk("ctrl3 ro", 32'h0000_0018, rd);
      apb(1'b0, 12'h100, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, {31'h0, err});
      set_src(20, 30, 0, 0);
      apb(1'b0, 12'h000, 32'h0000_0000);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk("empty level", 32'h0000_0000, rd);
      core.ack(3'h1, vec, ok);
      chk("core empty", 32'h0000_0000, {24'h0, vec});
      core.ack(3'h5, vec, ok);
      chk("core ok", 32'h0000_0001, {31'h0, ok});
      chk("core vector", 32'h0000_0054, {24'h0, vec});
      apb(1'b0, 12'h040, 32'h0000_0000);
      chk("core capture", 32'h0000_0056, rd);
      $display("test access done");
      apb(1'b1, 12'h044, 32'h0000_00F0);
      cpu_stopped <= 1'b1;
      @(posedge pclk);
      chk("wake lvl5", 32'h0000_0000, {31'h0, wake_up});
      set_src(7, 0, 0, 0);
      @(posedge pclk);
      chk("wake lvl7", 32'h0000_0001, {31'h0, wake_up});
      cpu_stopped <= 1'b0;
      @(posedge pclk);
      chk("wake run", 32'h0000_0000, {31'h0, wake_up});
      set_src(20, 0, 0, 0);
      apb(1'b1, 12'h044, 32'h0000_00C0);
      cpu_stopped <= 1'b1;
      @(posedge pclk);
      chk("wake mask4", 32'h0000_0001, {31'h0, wake_up});
      apb(1'b1, 12'h044, 32'h0000_0050);
      @(posedge pclk);
      chk("wake off", 32'h0000_0000, {31'h0, wake_up});
      $display("test wake done");
      cpu_stopped <= 1'b1;
      do_reset();
      chk("wake reset", 32'h0000_0000, {31'h0, wake_up});
      reg_check();
      $display("test reset done");
      finish_test();
   end
endmodule

/* File: verilog/iapw_ctrl.sv */
// acknowledge, prioritisation and wake-up logic of the interrupt controller
//
// Notes on behaviour
// - acknowledge with a winner returns its vector, loads capture
// - capture holds zero, level 6-4, priority 3-0
// - fixed-level winner captures priority eight
// - sources 1-63 ctrl; 1-7 fixed, 8-63 writable
// - ctrl: level 5-3, priority 2-0, 7 highest
// - fixed sources rank midpoint, read priority zero
// - ctrl 8-63 resets to disabled, never acknowledged
// - line 0 unused; lines 9-12 plain sources
// - level register reads and core cycles act alike
// - level ack picks best active source there
// - software ack picks highest level then priority
// - software ack with nothing: zero, capture cleared
// - vector in 7-0; level register own level
// - global level registers mirror level registers
// - wake mask clamped to 0-6
// - wake path purely combinational, level over mask
// - wake output goes to clock/system control
// - masked sources never win unless forced
// - forced sources active despite mask
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module iapw_ctrl #(
   parameter int ADDR_W = 12
) (
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [ADDR_W-1:0]         paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic [iapw_pkg::SRC_N:1]  src_pending,
   input  wire logic [iapw_pkg::SRC_N:1]  source_mask_bits,
   input  wire logic [iapw_pkg::SRC_N:1]  software_force_bits,
   input  wire logic                      interrupt_acknowledge_req,
   input  wire logic [2:0]                interrupt_acknowledge_level,
   output logic      [7:0]                interrupt_acknowledge_vector,
   output logic                           interrupt_acknowledge_valid,
   input  wire logic                      cpu_stopped,
   output logic                           wake_up
);

   // decode is hard-wired to a 12-bit map
   if (ADDR_W != 12) begin : g_bad_addr_w
      $error("iapw_ctrl: ADDR_W must be 12");
   end

   logic [2:0]                 lvl_q [iapw_pkg::FIXED_N+1:iapw_pkg::SRC_N];
   logic [2:0]                 pri_q [iapw_pkg::FIXED_N+1:iapw_pkg::SRC_N];
   iapw_pkg::iapw_lvl_vec_t    lvl_p;
   iapw_pkg::iapw_lvl_vec_t    pri_p;
   iapw_pkg::iapw_key_vec_t    key_p;
   logic [iapw_pkg::SRC_N:1]   active;
   logic [7:0]                 ack_level_priority_capture;
   logic [7:0]                 low_power_wake_ctrl;
   iapw_pkg::iapw_dec_t        dec;
   logic                       setup;
   logic                       done;
   logic [6:0]                 pick_b;
   logic [6:0]                 pick_i;
   logic [2:0]                 want_b;
   logic [7:0]                 vec_b;
   logic [7:0]                 vec_i;
   logic [7:0]                 capt_b;
   logic [7:0]                 capt_i;
   logic [31:0]                rd_val;
   logic [2:0]                 wake_mask;
   logic [2:0]                 top_lvl;

   // register decode, used by both phases of a transfer
   function automatic iapw_pkg::iapw_dec_t decode(input logic [11:0] a);
      iapw_pkg::iapw_dec_t d;
      d.kind = iapw_pkg::IAPW_R_NONE;
      d.idx  = 6'h00;
      if (a[1:0] == 2'h0) begin
         if (a == iapw_pkg::SWACK_OFS) begin
            d.kind = iapw_pkg::IAPW_R_SWACK;
         end else if (a[11:5] == iapw_pkg::LACK_OFS[11:5]) begin
            d.kind = iapw_pkg::IAPW_R_LACK;
            d.idx  = {3'h0, a[4:2]};
         end else if (a[11:5] == iapw_pkg::GLACK_OFS[11:5] && a[4:2] != 3'h0) begin
            d.kind = iapw_pkg::IAPW_R_LACK;
            d.idx  = {3'h0, a[4:2]};
         end else if (a == iapw_pkg::CAPT_OFS) begin
            d.kind = iapw_pkg::IAPW_R_CAPT;
         end else if (a == iapw_pkg::WAKE_OFS) begin
            d.kind = iapw_pkg::IAPW_R_WAKE;
         end else if (a > iapw_pkg::ICR_OFS && a <= iapw_pkg::ICR_LAST) begin
            d.kind = iapw_pkg::IAPW_R_ICR; // line 0 left unmapped
            d.idx  = a[7:2];
         end
      end
      return d;
   endfunction

   // winner search; want of zero means any level
   function automatic logic [6:0] pick(input logic [2:0] want,
                                       input logic [iapw_pkg::SRC_N:1] act,
                                       input iapw_pkg::iapw_lvl_vec_t lv,
                                       input iapw_pkg::iapw_key_vec_t kv);
      logic [6:0] best;
      logic [6:0] res;
      best = 7'h00;
      res  = 7'h00;
      for (int i = 1; i <= iapw_pkg::SRC_N; i++) begin
         if (act[i] && lv[i] != 3'h0 && (want == 3'h0 || lv[i] == want)
             && {lv[i], kv[i]} > best) begin
            best = {lv[i], kv[i]};
            res  = {1'b1, 6'(i)};
         end
      end
      return res;
   endfunction

   function automatic logic [7:0] vec_of(input logic [6:0] p);
      return p[6] ? iapw_pkg::VEC_BASE + {2'h0, p[5:0]} : iapw_pkg::VEC_NONE;
   endfunction

   function automatic logic [7:0] capt_of(input logic [6:0] p,
                                          input iapw_pkg::iapw_lvl_vec_t lv,
                                          input iapw_pkg::iapw_lvl_vec_t pv);
      logic [3:0] pr;
      pr = (p[5:0] <= 6'(iapw_pkg::FIXED_N)) ? iapw_pkg::MID_PRI
                                             : {1'b0, pv[p[5:0]]};
      return {1'b0, lv[p[5:0]], pr};
   endfunction

   // key doubles priority so fixed sources sit between 3 and 4
   always_comb begin
      for (int i = 1; i <= iapw_pkg::SRC_N; i++) begin
         if (i <= iapw_pkg::FIXED_N) begin
            lvl_p[i] = 3'(i);
            pri_p[i] = iapw_pkg::ICR_PRI_RST;
            key_p[i] = iapw_pkg::MID_KEY;
         end else begin
            lvl_p[i] = lvl_q[i];
            pri_p[i] = pri_q[i];
            key_p[i] = {pri_q[i], 1'b0};
         end
      end
   end

   assign active = (src_pending & ~source_mask_bits) | software_force_bits;
   assign dec    = decode(paddr);
   assign setup  = psel & ~penable;
   assign done   = psel & penable & pready;
   assign want_b = (dec.kind == iapw_pkg::IAPW_R_LACK) ? dec.idx[2:0] : 3'h0;
   assign pick_b = pick(want_b, active, lvl_p, key_p);
   assign pick_i = pick(interrupt_acknowledge_level, active, lvl_p, key_p);
   assign vec_b  = vec_of(pick_b);
   assign vec_i  = vec_of(pick_i);
   assign capt_b = capt_of(pick_b, lvl_p, pri_p);
   assign capt_i = capt_of(pick_i, lvl_p, pri_p);

   // writable control registers; reset level zero keeps a source out
   for (genvar g = iapw_pkg::FIXED_N + 1; g <= iapw_pkg::SRC_N; g++) begin : g_icr
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lvl_q[g] <= iapw_pkg::ICR_LVL_RST;
            pri_q[g] <= iapw_pkg::ICR_PRI_RST;
         end else if (done && pwrite && dec.kind == iapw_pkg::IAPW_R_ICR
                      && dec.idx == 6'(g)) begin
            lvl_q[g] <= pwdata[iapw_pkg::ICR_LVL_LSB +: 3];
            pri_q[g] <= pwdata[iapw_pkg::ICR_PRI_LSB +: 3];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power_wake_ctrl <= iapw_pkg::WAKE_RST;
      end else if (done && pwrite && dec.kind == iapw_pkg::IAPW_R_WAKE) begin
         low_power_wake_ctrl <= pwdata[7:0];
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (dec.kind)
         iapw_pkg::IAPW_R_SWACK: rd_val = {24'h00_0000, vec_b};
         iapw_pkg::IAPW_R_LACK:  rd_val = {24'h00_0000, vec_b};
         iapw_pkg::IAPW_R_CAPT:  rd_val = {24'h00_0000, ack_level_priority_capture};
         iapw_pkg::IAPW_R_WAKE:  rd_val = {24'h00_0000, low_power_wake_ctrl};
         iapw_pkg::IAPW_R_ICR:   rd_val = {26'h000_0000, lvl_p[dec.idx], pri_p[dec.idx]};
         iapw_pkg::IAPW_R_NONE:  rd_val = 32'h0000_0000;
         default:                rd_val = 32'h0000_0000;
      endcase
   end

   // answer is fixed: data and ready set at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup && dec.kind == iapw_pkg::IAPW_R_NONE;
         if (setup && !pwrite) begin
            prdata <= rd_val;
         end
      end
   end

   // ack side effects at the setup edge; a core cycle with a winner wins a tie
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_level_priority_capture <= iapw_pkg::CAPT_RST;
      end else if (interrupt_acknowledge_req && pick_i[6]) begin
         ack_level_priority_capture <= capt_i;
      end else if (setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_SWACK) begin
         ack_level_priority_capture <= pick_b[6] ? capt_b : iapw_pkg::CAPT_RST;
      end else if (setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_LACK && pick_b[6]) begin
         ack_level_priority_capture <= capt_b;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_acknowledge_valid  <= 1'b0;
         interrupt_acknowledge_vector <= iapw_pkg::VEC_NONE;
      end else begin
         interrupt_acknowledge_valid <= interrupt_acknowledge_req;
         if (interrupt_acknowledge_req) begin
            interrupt_acknowledge_vector <= vec_i;
         end
      end
   end

   // no flops on this path: the clock is off while stopped
   assign wake_mask = (low_power_wake_ctrl[iapw_pkg::WAKE_LVL_LSB +: 3] == iapw_pkg::LVL_TOP)
                      ? iapw_pkg::WAKE_LVL_MAX
                      : low_power_wake_ctrl[iapw_pkg::WAKE_LVL_LSB +: 3];
   always_comb begin
      wake_up = 1'b0;
      for (int i = 1; i <= iapw_pkg::SRC_N; i++) begin
         if (active[i] && lvl_p[i] > wake_mask) begin
            wake_up = low_power_wake_ctrl[iapw_pkg::WAKE_EN_BIT] & cpu_stopped;
         end
      end
   end

   // highest active level, worked out apart from the winner search
   always_comb begin
      top_lvl = 3'h0;
      for (int i = 1; i <= iapw_pkg::SRC_N; i++) begin
         if (active[i] && lvl_p[i] > top_lvl) begin
            top_lvl = lvl_p[i];
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_sw_read;
      setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_SWACK && !interrupt_acknowledge_req;
   endsequence
   sequence s_lv_hit;
      setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_LACK && pick_b[6] && !interrupt_acknowledge_req;
   endsequence
   sequence s_lv_miss;
      setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_LACK && !pick_b[6] && !interrupt_acknowledge_req;
   endsequence
   sequence s_ctrl_write;
      done && pwrite && dec.kind == iapw_pkg::IAPW_R_ICR && dec.idx > 6'(iapw_pkg::FIXED_N);
   endsequence

   a_capture_cleared_empty: assert property (
      s_sw_read ##0 !pick_b[6] |=> ack_level_priority_capture == 8'h00 && prdata == 32'h0)
      else $error("empty software ack did not clear capture");
   a_capture_reserved_zero: assert property (
      ack_level_priority_capture[7] == 1'b0)
      else $error("capture reserved bit set");
   a_fixed_pri_eight: assert property (
      s_sw_read ##0 (pick_b[6] && pick_b[5:0] <= 6'h07) |=>
      ack_level_priority_capture[3:0] == 4'h8)
      else $error("fixed source priority not eight");
   a_level_ack_level: assert property (
      s_lv_hit |=> ack_level_priority_capture[6:4] == $past(dec.idx[2:0]))
      else $error("level ack captured wrong level");
   a_vector_mapping: assert property (
      s_lv_hit |=> pready && prdata[7:0] == iapw_pkg::VEC_BASE + {2'h0, $past(pick_b[5:0])})
      else $error("level ack vector wrong");
   a_winner_unmasked: assert property (
      pick_b[6] |-> software_force_bits[pick_b[5:0]]
      || (src_pending[pick_b[5:0]] && !source_mask_bits[pick_b[5:0]]))
      else $error("masked source won");
   a_interrupt_acknowledge_alike: assert property (
      interrupt_acknowledge_req && pick_i[6] |=> interrupt_acknowledge_valid && interrupt_acknowledge_vector == $past(vec_i)
      && ack_level_priority_capture[6:4] == $past(interrupt_acknowledge_level))
      else $error("core ack cycle differs from register read");
   a_wake_top_level: assert property (
      low_power_wake_ctrl[7] && cpu_stopped && (|(active & {56'h0, 7'h40})) |-> wake_up)
      else $error("level seven source did not wake");
   a_wake_needs_enable: assert property (
      !low_power_wake_ctrl[7] || !cpu_stopped |-> !wake_up)
      else $error("wake without enable");
   a_fixed_ctrl_read: assert property (
      setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_ICR && dec.idx < 6'h08 |=>
      prdata[2:0] == 3'h0 && prdata[5:3] == $past(dec.idx[2:0]))
      else $error("fixed control register read wrong");

   a_sw_top_level: assert property (
      s_sw_read |=> ack_level_priority_capture[6:4] == $past(top_lvl))
      else $error("software ack missed the top level");

   a_level_empty_kept: assert property (
      s_lv_miss |=> prdata == 32'h0000_0000 && $stable(ack_level_priority_capture))
      else $error("empty level ack changed data or capture");

   // capture moves only on an acknowledge; anything else would hide the last winner
   a_capture_held: assert property (
      !interrupt_acknowledge_req && !(setup && !pwrite && (dec.kind == iapw_pkg::IAPW_R_SWACK
                                          || dec.kind == iapw_pkg::IAPW_R_LACK))
      |=> $stable(ack_level_priority_capture))
      else $error("capture changed without an acknowledge");

   a_ready_pulse: assert property (
      setup |=> pready ##1 !pready)
      else $error("ready not a one-cycle answer");

   a_unmapped_error: assert property (
      setup && dec.kind == iapw_pkg::IAPW_R_NONE |=> pready && pslverr)
      else $error("unmapped access not refused");

   a_mapped_no_error: assert property (
      setup && dec.kind != iapw_pkg::IAPW_R_NONE |=> !pslverr)
      else $error("mapped access refused");

   a_ctrl_write_lands: assert property (
      s_ctrl_write |=> lvl_p[$past(dec.idx)] == $past(pwdata[5:3])
      && pri_p[$past(dec.idx)] == $past(pwdata[2:0]))
      else $error("control register write lost");

   a_interrupt_acknowledge_one_pulse: assert property (
      interrupt_acknowledge_valid |-> $past(interrupt_acknowledge_req))
      else $error("core answer without a request");

   a_interrupt_acknowledge_no_source: assert property (
      interrupt_acknowledge_req && !pick_i[6] && !setup |=> interrupt_acknowledge_valid && interrupt_acknowledge_vector == 8'h00
      && $stable(ack_level_priority_capture))
      else $error("empty core ack not answered with zero");

   // wake cross-check from the top level alone, clamp written as its own case
   a_wake_matches_levels: assert property (
      wake_up == (low_power_wake_ctrl[7] && cpu_stopped
                  && (top_lvl > low_power_wake_ctrl[6:4] || top_lvl == 3'h7)))
      else $error("wake output disagrees with active levels");

   a_prdata_hold: assert property (
      !(setup && !pwrite) |=> $stable(prdata))
      else $error("read data moved outside a read");

   a_upper_bits_zero: assert property (
      setup && !pwrite |=> prdata[31:8] == 24'h00_0000)
      else $error("upper read data bits set");

   a_ctrl_reserved_zero: assert property (
      setup && !pwrite && dec.kind == iapw_pkg::IAPW_R_ICR |=> prdata[7:6] == 2'h0)
      else $error("control reserved bits set");

   a_global_mirror: assert property (
      setup && paddr[11:5] == 7'h01 && paddr[4:2] != 3'h0 && paddr[1:0] == 2'h0
      |-> dec.kind == iapw_pkg::IAPW_R_LACK && dec.idx[2:0] == paddr[4:2])
      else $error("global level register not mirrored");
endmodule

/* File: verilog/iapw_pkg.sv */
// constants, field layout and register map of the acknowledge/priority/wake block
package iapw_pkg;
   localparam int SRC_N   = 63;
   localparam int FIXED_N = 7;

   localparam logic [11:0] SWACK_OFS = 12'h000;
   localparam logic [11:0] LACK_OFS  = 12'h000;
   localparam logic [11:0] GLACK_OFS = 12'h020;
   localparam logic [11:0] CAPT_OFS  = 12'h040;
   localparam logic [11:0] WAKE_OFS  = 12'h044;
   localparam logic [11:0] ICR_OFS   = 12'h100;
   localparam logic [11:0] ICR_LAST  = 12'h1FC;

   localparam int CAPT_LVL_LSB = 4;
   localparam int CAPT_PRI_LSB = 0;
   localparam int ICR_LVL_LSB  = 3;
   localparam int ICR_PRI_LSB  = 0;
   localparam int WAKE_EN_BIT  = 7;
   localparam int WAKE_LVL_LSB = 4;

   localparam logic [7:0] CAPT_RST    = 8'h00;
   localparam logic [7:0] WAKE_RST    = 8'h00;
   localparam logic [2:0] ICR_LVL_RST = 3'h0;
   localparam logic [2:0] ICR_PRI_RST = 3'h0;
   localparam logic [3:0] MID_PRI     = 4'h8;
   localparam logic [3:0] MID_KEY     = 4'h7;
   localparam logic [2:0] WAKE_LVL_MAX = 3'h6;
   localparam logic [2:0] LVL_TOP     = 3'h7;
   localparam logic [7:0] VEC_BASE    = 8'h40;
   localparam logic [7:0] VEC_NONE    = 8'h00;

   typedef enum logic [2:0] {
      IAPW_R_NONE  = 3'b000,
      IAPW_R_SWACK = 3'b001,
      IAPW_R_LACK  = 3'b010,
      IAPW_R_CAPT  = 3'b011,
      IAPW_R_WAKE  = 3'b100,
      IAPW_R_ICR   = 3'b101
   } iapw_reg_t;

   typedef struct packed {
      iapw_reg_t  kind;
      logic [5:0] idx;
   } iapw_dec_t;

   typedef logic [SRC_N:1][2:0] iapw_lvl_vec_t;
   typedef logic [SRC_N:1][3:0] iapw_key_vec_t;
endpackage
